// file: dv/dmac_asserts.sv
// concurrent checks on the command link between the host end and the controller end
`timescale 1ns/100ps
module dmac_asserts (
  input logic aclk,
  input logic aresetn,
  input logic cmd_valid,
  input logic cmd_ready,
  input dmac_pkg::dmac_op_t cmd_op,
  input logic [1:0] cmd_chan,
  input logic cmd_alt,
  input logic [31:0] cmd_data,
  input logic rsp_valid,
  input logic [31:0] rsp_data,
  input logic irq_sw,
  input logic irq_err
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic clr_err;
  logic get_done;
  assign clr_err = cmd_valid && cmd_op == dmac_pkg::OP_ERR_CLR;
  assign get_done = cmd_valid && cmd_op == dmac_pkg::OP_DONE_GET;

  a_rsp_next: assert property (cmd_valid && cmd_ready |=> rsp_valid)
    else $error("no response after a taken command");
  a_rsp_cause: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("response without a command");
  a_cmd_single: assert property (cmd_valid |=> !cmd_valid)
    else $error("command held past one cycle");
  a_struct_addr: assert property (cmd_valid && cmd_op == dmac_pkg::OP_STRUCT_ADDR |=>
    rsp_data[9:0] == {$past(cmd_alt), 3'h0, $past(cmd_chan), 4'h0})
    else $error("structure address low bits wrong");
  a_isen_flag: assert property (cmd_valid && cmd_op == dmac_pkg::OP_CH_ISEN |=> rsp_data[31:1] == 31'h0)
    else $error("enable readback wider than one bit");
  a_write_quiet: assert property (cmd_valid && cmd_op inside {dmac_pkg::OP_CH_EN, dmac_pkg::OP_CH_DIS,
    dmac_pkg::OP_SW_REQ, dmac_pkg::OP_XFER_SET} |=> rsp_data == 32'h0)
    else $error("write-type command returned data");
  a_err_hold: assert property (irq_err && !clr_err && !$past(clr_err) |=> irq_err)
    else $error("error interrupt dropped without clear");
  a_err_read: assert property (cmd_valid && cmd_op == dmac_pkg::OP_ERR_GET |=>
    (rsp_data != 32'h0) == $past(irq_err))
    else $error("error status read disagrees with flag");
  a_sw_fall: assert property ($fell(irq_sw) |-> $past(get_done) || $past(get_done, 2))
    else $error("software interrupt fell without service");
  a_done_read: assert property (get_done && irq_sw |=> rsp_data != 32'h0)
    else $error("done read empty while interrupt pending");
endmodule : dmac_asserts

// file: dv/tb_top.sv
// self-checking bench: both ends joined, axi4-lite stimulus, memory and request stand-ins
`timescale 1ns/100ps
module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, mem_addr, mem_wdata, mem_rdata, res;
  logic [3:0] wstrb, periph_single, periph_burst, periph_done, pdone_last;
  logic [1:0] bresp, rresp, resp, mem_size;
  logic mem_req, mem_we, mem_ack, mem_err, err_inj;
  int errors, n_tests, n_pdone;
  logic [31:0] wr_addr[$], wr_data[$];
  logic [1:0] wr_size[$];
  dmac_if lnk ();
  dmac_host i_dmac_host (.aclk, .aresetn, .bus(lnk), .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  dmac_dev i_dmac_dev (.aclk, .aresetn, .bus(lnk), .periph_single, .periph_burst, .periph_done, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_size, .mem_rdata, .mem_ack, .mem_err);
  dmac_asserts i_dmac_asserts (.aclk(aclk), .aresetn(aresetn), .cmd_valid(lnk.cmd_valid),
    .cmd_ready(lnk.cmd_ready), .cmd_op(lnk.cmd_op), .cmd_chan(lnk.cmd_chan), .cmd_alt(lnk.cmd_alt),
    .cmd_data(lnk.cmd_data), .rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data), .irq_sw(lnk.irq_sw),
    .irq_err(lnk.irq_err));

  function automatic logic [31:0] pat(input logic [31:0] a);
    return {16'h5a00 ^ a[15:0], a[15:0]};
  endfunction : pat

  // memory answers every beat one cycle late, so each beat spans two edges
  always @(posedge aclk) begin
    mem_ack <= mem_req && !mem_ack;
    mem_err <= mem_req && !mem_ack && err_inj;
    mem_rdata <= pat(mem_addr);
    if (mem_req && mem_ack && mem_we) begin
      wr_addr.push_back(mem_addr);
      wr_data.push_back(mem_wdata);
      wr_size.push_back(mem_size);
    end
    if (periph_done != 4'h0) begin
      n_pdone++;
      pdone_last <= periph_done;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask : chk

  // handshakes are judged at the rising edge, before the design's own updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(posedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      resp = bresp;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(posedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      res = rdata;
      resp = rresp;
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic stat_wait(input int b);
    res = 32'h0;
    while (!res[b]) rd(dmac_pkg::REG_STATUS);
  endtask : stat_wait

  task automatic cmd(input dmac_pkg::dmac_op_t op, input logic [1:0] ch, input logic alt, input logic [31:0] arg);
    wr(dmac_pkg::REG_ARG, arg);
    wr(dmac_pkg::REG_CMD, {19'h0, alt, 2'h0, ch, 3'h0, op});
    // busy may already have fallen by the first status read
    rd(dmac_pkg::REG_STATUS);
    while (res[0]) rd(dmac_pkg::REG_STATUS);
    rd(dmac_pkg::REG_RESULT);
  endtask : cmd

  task automatic prog(input logic [1:0] ch, input logic alt, input logic [1:0] sz, input logic [31:0] xf);
    cmd(dmac_pkg::OP_CTRL_SET, ch, alt, {26'h0, sz, sz, sz});
    // addresses, size and mode before enable
    cmd(dmac_pkg::OP_SRC_SET, ch, alt, 32'h0000_0100);
    cmd(dmac_pkg::OP_DST_SET, ch, alt, 32'h0000_0800);
    cmd(dmac_pkg::OP_XFER_SET, ch, alt, xf);
    cmd(dmac_pkg::OP_CH_EN, ch, 1'b0, 32'h0);
    wr_addr.delete();
    wr_data.delete();
    wr_size.delete();
  endtask : prog

  task automatic req(input logic [3:0] s, input logic [3:0] b, input int n);
    periph_single <= s;
    periph_burst <= b;
    repeat (n) @(posedge aclk);
    periph_single <= 4'h0;
    periph_burst <= 4'h0;
    repeat (20) @(posedge aclk);
  endtask : req

  task automatic results();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    repeat (40000) @(posedge aclk);
    errors++;
    results();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, err_inj} <= 7'h0;
    {awaddr, araddr, wdata} <= 48'h0;
    {periph_single, periph_burst} <= 8'h0;
    wstrb <= 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h40);
    chk({30'h0, resp}, {30'h0, dmac_pkg::RESP_SLVERR});
    chk(res, 32'h0);
    wr(8'h40, 32'h1);
    chk({30'h0, resp}, {30'h0, dmac_pkg::RESP_SLVERR});
    cmd(dmac_pkg::OP_GLOBAL_EN, 2'h0, 1'b0, 32'h0);
    cmd(dmac_pkg::OP_BASE_SET, 2'h0, 1'b0, 32'h0000_2400);
    for (int i = 0; i < 8; i++) begin
      cmd(dmac_pkg::OP_STRUCT_ADDR, i[1:0], i[2], 32'h0);
      chk(res, {22'h9, i[2], 3'h0, i[1:0], 4'h0});
    end
    for (int b = 0; b < 8; b++) begin
      cmd(b < 4 ? dmac_pkg::OP_ATTR_SET : dmac_pkg::OP_ATTR_CLR, 2'h3, 1'b0, 32'h1 << b[1:0]);
      cmd(dmac_pkg::OP_ATTR_GET, 2'h3, 1'b0, 32'h0);
      chk(res, {28'h0, b < 4 ? 4'hf >> (3 - b) : 4'he << b[1:0]});
    end
    for (int s = 0; s < 3; s++) begin
      prog(2'h0, 1'b0, s[1:0], 32'h0002_0002);
      cmd(dmac_pkg::OP_CH_ISEN, 2'h0, 1'b0, 32'h0);
      chk(res, 32'h1);
      cmd(dmac_pkg::OP_SW_REQ, 2'h0, 1'b0, 32'h0);
      stat_wait(1);
      chk(32'(wr_addr.size()), 32'h2);
      chk(wr_addr[1], 32'h800 + (32'h1 << s));
      chk({30'h0, wr_size[0]}, 32'(s));
      if (s == 2) chk(wr_data[1], pat(32'h104));
      cmd(dmac_pkg::OP_CH_ISEN, 2'h0, 1'b0, 32'h0);
      chk(res, 32'h0);
      cmd(dmac_pkg::OP_SIZE_GET, 2'h0, 1'b0, 32'h0);
      chk(res, 32'h0);
      cmd(dmac_pkg::OP_MODE_GET, 2'h0, 1'b0, 32'h0);
      chk(res, 32'h0);
      cmd(dmac_pkg::OP_DONE_GET, 2'h0, 1'b0, 32'h0);
      chk(res, 32'h1);
      rd(dmac_pkg::REG_STATUS);
      chk({31'h0, res[1]}, 32'h0);
    end
    chk(32'(n_pdone), 32'h0);
    cmd(dmac_pkg::OP_MAP_SET, 2'h1, 1'b0, 32'h2);
    cmd(dmac_pkg::OP_ATTR_SET, 2'h1, 1'b0, 32'h8);
    prog(2'h1, 1'b0, 2'h2, 32'h0001_0008);
    req(4'h4, 4'h0, 30);
    cmd(dmac_pkg::OP_SIZE_GET, 2'h1, 1'b0, 32'h0);
    chk(res, 32'h8);
    cmd(dmac_pkg::OP_ATTR_CLR, 2'h1, 1'b0, 32'h8);
    cmd(dmac_pkg::OP_ATTR_SET, 2'h1, 1'b0, 32'h1);
    req(4'h4, 4'h0, 30);
    cmd(dmac_pkg::OP_SIZE_GET, 2'h1, 1'b0, 32'h0);
    chk(res, 32'h8);
    req(4'h0, 4'h4, 12);
    cmd(dmac_pkg::OP_SIZE_GET, 2'h1, 1'b0, 32'h0);
    chk({31'h0, res > 0 && res < 8}, 32'h1);
    periph_burst <= 4'h4;
    while (n_pdone == 0) @(posedge aclk);
    periph_burst <= 4'h0;
    rd(dmac_pkg::REG_STATUS);
    chk({28'h0, pdone_last}, 32'h4);
    chk({31'h0, res[1]}, 32'h0);
    // hardware-started auto transfer outlives a short burst
    prog(2'h1, 1'b0, 2'h2, 32'h0002_0003);
    req(4'h0, 4'h4, 3);
    cmd(dmac_pkg::OP_SIZE_GET, 2'h1, 1'b0, 32'h0);
    chk(res, 32'h0);
    prog(2'h3, 1'b0, 2'h2, 32'h0002_0005);
    cmd(dmac_pkg::OP_CH_DIS, 2'h3, 1'b0, 32'h0);
    cmd(dmac_pkg::OP_SW_REQ, 2'h3, 1'b0, 32'h0);
    repeat (20) @(posedge aclk);
    cmd(dmac_pkg::OP_SIZE_GET, 2'h3, 1'b0, 32'h0);
    chk(res, 32'h5);
    cmd(dmac_pkg::OP_GLOBAL_DIS, 2'h0, 1'b0, 32'h0);
    cmd(dmac_pkg::OP_CH_EN, 2'h3, 1'b0, 32'h0);
    cmd(dmac_pkg::OP_SW_REQ, 2'h3, 1'b0, 32'h0);
    repeat (40) @(posedge aclk);
    cmd(dmac_pkg::OP_SIZE_GET, 2'h3, 1'b0, 32'h0);
    chk(res, 32'h5);
    cmd(dmac_pkg::OP_CH_DIS, 2'h3, 1'b0, 32'h0);
    cmd(dmac_pkg::OP_GLOBAL_EN, 2'h0, 1'b0, 32'h0);
    cmd(dmac_pkg::OP_ATTR_SET, 2'h2, 1'b0, 32'h2);
    prog(2'h2, 1'b1, 2'h2, 32'h0002_0002);
    cmd(dmac_pkg::OP_SW_REQ, 2'h2, 1'b0, 32'h0);
    stat_wait(1);
    chk(32'(wr_addr.size()), 32'h2);
    cmd(dmac_pkg::OP_MODE_GET, 2'h2, 1'b1, 32'h0);
    chk(res, 32'h0);
    cmd(dmac_pkg::OP_DONE_GET, 2'h0, 1'b0, 32'h0);
    chk(res, 32'h4);
    // both requests wait behind the global gate; the high-priority one moves first
    cmd(dmac_pkg::OP_GLOBAL_DIS, 2'h0, 1'b0, 32'h0);
    cmd(dmac_pkg::OP_ATTR_SET, 2'h1, 1'b0, 32'h4);
    prog(2'h0, 1'b0, 2'h2, 32'h0002_0002);
    prog(2'h1, 1'b0, 2'h1, 32'h0002_0002);
    cmd(dmac_pkg::OP_SW_REQ, 2'h0, 1'b0, 32'h0);
    cmd(dmac_pkg::OP_SW_REQ, 2'h1, 1'b0, 32'h0);
    cmd(dmac_pkg::OP_GLOBAL_EN, 2'h0, 1'b0, 32'h0);
    while (wr_addr.size() < 4) @(posedge aclk);
    chk({30'h0, wr_size[0]}, 32'h1);
    cmd(dmac_pkg::OP_DONE_GET, 2'h0, 1'b0, 32'h0);
    chk(res, 32'h3);
    err_inj <= 1'b1;
    prog(2'h0, 1'b0, 2'h2, 32'h0002_0002);
    cmd(dmac_pkg::OP_SW_REQ, 2'h0, 1'b0, 32'h0);
    stat_wait(2);
    err_inj <= 1'b0;
    cmd(dmac_pkg::OP_ERR_GET, 2'h0, 1'b0, 32'h0);
    chk({31'h0, res != 0}, 32'h1);
    repeat (10) @(posedge aclk);
    rd(dmac_pkg::REG_STATUS);
    chk({31'h0, res[2]}, 32'h1);
    cmd(dmac_pkg::OP_ERR_CLR, 2'h0, 1'b0, 32'h0);
    rd(dmac_pkg::REG_STATUS);
    chk({31'h0, res[2]}, 32'h0);
    results();
  end
endmodule : tb_top

// file: verilog/dmac_dev.sv
// multichannel dma controller: channel state, arbiter and transfer engine
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module dmac_dev (
  input wire logic aclk,
  input wire logic aresetn,
  dmac_if.dev bus,
  input wire logic [3:0] periph_single,
  input wire logic [3:0] periph_burst,
  output logic [3:0] periph_done,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [1:0] mem_size,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic mem_err
);
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dmac_state_t;

  function automatic logic [31:0] dmac_inc(input logic [1:0] inc);
    logic [31:0] v;
    v = 32'h0;
    unique case (inc)
      2'h0: v = 32'h1;
      2'h1: v = 32'h2;
      2'h2: v = 32'h4;
      2'h3: v = 32'h0;
    endcase
    return v;
  endfunction : dmac_inc

  logic [3:0] single_m_r, single_s_r, burst_m_r, burst_s_r;
  logic gen_en_r;
  logic [31:0] base_r;
  logic [3:0] attr_r [dmac_pkg::NCH];
  logic [1:0] map_r [dmac_pkg::NCH];
  logic [31:0] src_r [dmac_pkg::NCH][2];
  logic [31:0] dst_r [dmac_pkg::NCH][2];
  logic [dmac_pkg::CW-1:0] cnt_r [dmac_pkg::NCH][2];
  logic [5:0] ctl_r [dmac_pkg::NCH][2];
  dmac_pkg::dmac_mode_t mode_r [dmac_pkg::NCH][2];
  logic [dmac_pkg::NCH-1:0] ch_en_r, swreq_r, sw_done_r, cur_alt_r;
  logic err_r;
  dmac_state_t state_r;
  logic [1:0] act_ch_r;
  logic act_alt_r, act_hold_r, act_sw_r;
  logic [31:0] data_r;
  logic [3:0] periph_done_r;
  logic rsp_valid_r;
  logic [31:0] rsp_data_r;
  logic [dmac_pkg::NCH-1:0] hw_req, pend, eff_alt;
  logic pick_ok;
  logic [1:0] pick;
  logic [31:0] rd_val;
  logic [1:0] c_ch;
  logic c_alt;

  // peripheral pins come from other domains
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      single_m_r <= 4'h0;
      single_s_r <= 4'h0;
      burst_m_r <= 4'h0;
      burst_s_r <= 4'h0;
    end else begin
      single_m_r <= periph_single;
      single_s_r <= single_m_r;
      burst_m_r <= periph_burst;
      burst_s_r <= burst_m_r;
    end
  end

  always_comb begin
    for (int c = 0; c < dmac_pkg::NCH; c++) begin
      hw_req[c] = !attr_r[c][dmac_pkg::ATTR_REQMASK] && (burst_s_r[map_r[c]]
        || (!attr_r[c][dmac_pkg::ATTR_BURST] && single_s_r[map_r[c]]));
      eff_alt[c] = cur_alt_r[c] ^ attr_r[c][dmac_pkg::ATTR_ALT];
      pend[c] = gen_en_r && ch_en_r[c] && (swreq_r[c] || hw_req[c]);
    end
  end

  always_comb begin
    pick_ok = 1'b0;
    pick = 2'h0;
    for (int c = dmac_pkg::NCH - 1; c >= 0; c--) begin
      if (pend[c] && !attr_r[c][dmac_pkg::ATTR_HIPRI]) begin
        pick_ok = 1'b1;
        pick = 2'(c);
      end
    end
    for (int c = dmac_pkg::NCH - 1; c >= 0; c--) begin
      if (pend[c] && attr_r[c][dmac_pkg::ATTR_HIPRI]) begin
        pick_ok = 1'b1;
        pick = 2'(c);
      end
    end
  end

  assign c_ch = bus.cmd_chan;
  assign c_alt = bus.cmd_alt;

  always_comb begin
    rd_val = 32'h0;
    unique case (bus.cmd_op)
      dmac_pkg::OP_STRUCT_ADDR: begin
        rd_val = base_r;
        rd_val[dmac_pkg::STRUCT_ALT_BIT] = c_alt;
        rd_val[dmac_pkg::STRUCT_CH_LSB +: 2] = c_ch;
      end
      dmac_pkg::OP_ATTR_GET: rd_val = {28'h0, attr_r[c_ch]};
      dmac_pkg::OP_CH_ISEN: rd_val = {31'h0, ch_en_r[c_ch]};
      dmac_pkg::OP_MODE_GET: rd_val = {29'h0, mode_r[c_ch][c_alt]};
      dmac_pkg::OP_SIZE_GET: rd_val = {21'h0, cnt_r[c_ch][c_alt]};
      dmac_pkg::OP_DONE_GET: rd_val = {28'h0, sw_done_r};
      dmac_pkg::OP_ERR_GET: rd_val = {31'h0, err_r};
      default: rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 32'h0;
    end else begin
      rsp_valid_r <= bus.cmd_valid;
      rsp_data_r <= bus.cmd_valid ? rd_val : 32'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_en_r <= 1'b0;
      base_r <= dmac_pkg::RST_BASE;
      ch_en_r <= '0;
      swreq_r <= '0;
      sw_done_r <= '0;
      cur_alt_r <= '0;
      err_r <= 1'b0;
      periph_done_r <= 4'h0;
      state_r <= ST_IDLE;
      act_ch_r <= 2'h0;
      act_alt_r <= 1'b0;
      act_hold_r <= 1'b0;
      act_sw_r <= 1'b0;
      data_r <= 32'h0;
      for (int c = 0; c < dmac_pkg::NCH; c++) begin
        attr_r[c] <= dmac_pkg::RST_ATTR;
        map_r[c] <= dmac_pkg::RST_MAP;
        for (int a = 0; a < 2; a++) begin
          src_r[c][a] <= dmac_pkg::RST_ADDR;
          dst_r[c][a] <= dmac_pkg::RST_ADDR;
          cnt_r[c][a] <= '0;
          ctl_r[c][a] <= dmac_pkg::RST_CTL;
          mode_r[c][a] <= dmac_pkg::MODE_STOP;
        end
      end
    end else begin
      periph_done_r <= 4'h0;
      if (bus.cmd_valid) begin
        unique case (bus.cmd_op)
          dmac_pkg::OP_GLOBAL_EN: gen_en_r <= 1'b1;
          dmac_pkg::OP_GLOBAL_DIS: gen_en_r <= 1'b0;
          // low ten bits forced to zero
          dmac_pkg::OP_BASE_SET: base_r <= bus.cmd_data & dmac_pkg::TABLE_ALIGN_MASK;
          dmac_pkg::OP_ATTR_SET: attr_r[c_ch] <= attr_r[c_ch] | bus.cmd_data[3:0];
          dmac_pkg::OP_ATTR_CLR: attr_r[c_ch] <= attr_r[c_ch] & ~bus.cmd_data[3:0];
          dmac_pkg::OP_CTRL_SET: ctl_r[c_ch][c_alt] <= bus.cmd_data[5:0];
          dmac_pkg::OP_SRC_SET: src_r[c_ch][c_alt] <= bus.cmd_data;
          dmac_pkg::OP_DST_SET: dst_r[c_ch][c_alt] <= bus.cmd_data;
          dmac_pkg::OP_XFER_SET: begin
            cnt_r[c_ch][c_alt] <= bus.cmd_data[dmac_pkg::XFER_CNT_LSB +: dmac_pkg::CW];
            mode_r[c_ch][c_alt] <= dmac_pkg::dmac_mode_t'(bus.cmd_data[dmac_pkg::XFER_MODE_LSB +: 3]);
          end
          dmac_pkg::OP_CH_EN: begin
            ch_en_r[c_ch] <= 1'b1;
            cur_alt_r[c_ch] <= 1'b0;
          end
          dmac_pkg::OP_CH_DIS: begin
            ch_en_r[c_ch] <= 1'b0;
            swreq_r[c_ch] <= 1'b0;
          end
          dmac_pkg::OP_SW_REQ: swreq_r[c_ch] <= ch_en_r[c_ch];
          dmac_pkg::OP_MAP_SET: map_r[c_ch] <= bus.cmd_data[1:0];
          dmac_pkg::OP_DONE_GET: sw_done_r <= '0;
          dmac_pkg::OP_ERR_CLR: err_r <= 1'b0;
          default: ;
        endcase
      end
      unique case (state_r)
        ST_IDLE: begin
          if (pick_ok) begin
            act_ch_r <= pick;
            act_alt_r <= eff_alt[pick];
            act_sw_r <= swreq_r[pick];
            swreq_r[pick] <= 1'b0;
            act_hold_r <= swreq_r[pick] || mode_r[pick][eff_alt[pick]] != dmac_pkg::MODE_BASIC;
            if (mode_r[pick][eff_alt[pick]] == dmac_pkg::MODE_STOP || cnt_r[pick][eff_alt[pick]] == '0)
              ch_en_r[pick] <= 1'b0;
            else
              state_r <= ST_READ;
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            data_r <= mem_rdata;
            state_r <= mem_err ? ST_IDLE : ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (mem_ack) begin
            src_r[act_ch_r][act_alt_r] <= src_r[act_ch_r][act_alt_r]
              + dmac_inc(ctl_r[act_ch_r][act_alt_r][dmac_pkg::CTL_SRC_INC_LSB +: 2]);
            dst_r[act_ch_r][act_alt_r] <= dst_r[act_ch_r][act_alt_r]
              + dmac_inc(ctl_r[act_ch_r][act_alt_r][dmac_pkg::CTL_DST_INC_LSB +: 2]);
            cnt_r[act_ch_r][act_alt_r] <= cnt_r[act_ch_r][act_alt_r] - 1'b1;
            state_r <= ST_IDLE;
            if (mem_err) begin
              src_r[act_ch_r][act_alt_r] <= src_r[act_ch_r][act_alt_r];
              dst_r[act_ch_r][act_alt_r] <= dst_r[act_ch_r][act_alt_r];
              cnt_r[act_ch_r][act_alt_r] <= cnt_r[act_ch_r][act_alt_r];
            end else if (cnt_r[act_ch_r][act_alt_r] == 11'h001) begin
              mode_r[act_ch_r][act_alt_r] <= dmac_pkg::MODE_STOP;
              if (mode_r[act_ch_r][act_alt_r] >= dmac_pkg::MODE_PINGPONG
                  && mode_r[act_ch_r][!act_alt_r] != dmac_pkg::MODE_STOP) begin
                cur_alt_r[act_ch_r] <= !cur_alt_r[act_ch_r];
                swreq_r[act_ch_r] <= act_sw_r;
              end else begin
                ch_en_r[act_ch_r] <= 1'b0;
                if (act_sw_r)
                  sw_done_r[act_ch_r] <= 1'b1;
                else
                  periph_done_r[map_r[act_ch_r]] <= 1'b1;
              end
            end else if (gen_en_r && ch_en_r[act_ch_r] && (act_hold_r || hw_req[act_ch_r])) begin
              state_r <= ST_READ;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      if (state_r != ST_IDLE && mem_ack && mem_err) begin
        err_r <= 1'b1;
        ch_en_r[act_ch_r] <= 1'b0;
      end
    end
  end

  assign mem_req = state_r != ST_IDLE;
  assign mem_we = state_r == ST_WRITE;
  assign mem_addr = mem_we ? dst_r[act_ch_r][act_alt_r] : src_r[act_ch_r][act_alt_r];
  assign mem_wdata = data_r;
  assign mem_size = ctl_r[act_ch_r][act_alt_r][dmac_pkg::CTL_SIZE_LSB +: 2];
  assign periph_done = periph_done_r;
  assign bus.cmd_ready = 1'b1;
  assign bus.rsp_valid = rsp_valid_r;
  assign bus.rsp_data = rsp_data_r;
  assign bus.irq_sw = |sw_done_r;
  assign bus.irq_err = err_r;
endmodule : dmac_dev

// file: verilog/dmac_host.sv
// host end: axi4-lite register slave that issues controller commands
`timescale 1ns/100ps
module dmac_host (
  input wire logic aclk,
  input wire logic aresetn,
  dmac_if.host bus,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r, busy_r, cmd_valid_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r, arg_r, result_r, rdata_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] cmd_word_r;
  logic do_write;

  assign awready = !aw_got_r && !bvalid_r;
  assign wready = !w_got_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign do_write = aw_got_r && w_got_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= dmac_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (do_write) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (aw_addr_r == dmac_pkg::REG_CMD || aw_addr_r == dmac_pkg::REG_ARG)
          ? dmac_pkg::RESP_OKAY : dmac_pkg::RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // argument register honours byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arg_r <= 32'h0;
    end else if (do_write && aw_addr_r == dmac_pkg::REG_ARG) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_r[b])
          arg_r[8*b +: 8] <= w_data_r[8*b +: 8];
      end
    end
  end

  // a command written while one is outstanding is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_valid_r <= 1'b0;
      busy_r <= 1'b0;
      cmd_word_r <= 32'h0;
      result_r <= 32'h0;
    end else begin
      if (cmd_valid_r && bus.cmd_ready)
        cmd_valid_r <= 1'b0;
      if (bus.rsp_valid) begin
        busy_r <= 1'b0;
        result_r <= bus.rsp_data;
      end
      if (do_write && aw_addr_r == dmac_pkg::REG_CMD && !busy_r) begin
        cmd_valid_r <= 1'b1;
        busy_r <= 1'b1;
        cmd_word_r <= w_data_r;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= dmac_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= dmac_pkg::RESP_OKAY;
      unique case (araddr)
        dmac_pkg::REG_CMD: rdata_r <= cmd_word_r;
        dmac_pkg::REG_ARG: rdata_r <= arg_r;
        dmac_pkg::REG_RESULT: rdata_r <= result_r;
        dmac_pkg::REG_STATUS: rdata_r <= {29'h0, bus.irq_err, bus.irq_sw, busy_r};
        default: begin
          rdata_r <= 32'h0;
          rresp_r <= dmac_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign bus.cmd_valid = cmd_valid_r;
  assign bus.cmd_op = dmac_pkg::dmac_op_t'(cmd_word_r[dmac_pkg::CMD_OP_LSB +: 5]);
  assign bus.cmd_chan = cmd_word_r[dmac_pkg::CMD_CHAN_LSB +: 2];
  assign bus.cmd_alt = cmd_word_r[dmac_pkg::CMD_ALT_BIT];
  assign bus.cmd_data = arg_r;
endmodule : dmac_host

// file: verilog/dmac_if.sv
// command link between the programming host end and the dma controller end
`timescale 1ns/100ps
interface dmac_if;
  logic cmd_valid;
  logic cmd_ready;
  dmac_pkg::dmac_op_t cmd_op;
  logic [1:0] cmd_chan;
  logic cmd_alt;
  logic [31:0] cmd_data;
  logic rsp_valid;
  logic [31:0] rsp_data;
  logic irq_sw;
  logic irq_err;

  modport dev (
    input cmd_valid, cmd_op, cmd_chan, cmd_alt, cmd_data,
    output cmd_ready, rsp_valid, rsp_data, irq_sw, irq_err
  );
  modport host (
    output cmd_valid, cmd_op, cmd_chan, cmd_alt, cmd_data,
    input cmd_ready, rsp_valid, rsp_data, irq_sw, irq_err
  );
endinterface : dmac_if

// file: verilog/dmac_pkg.sv
// shared constants, command set and mode encodings of the dma controller
package dmac_pkg;
  localparam int NCH = 4;
  localparam int NPER = 4;
  localparam int CW = 11;
  // control table sits on a 1024-byte boundary
  localparam logic [31:0] TABLE_ALIGN_MASK = 32'hffff_fc00;
  localparam logic [31:0] RST_BASE = 32'h0000_0000;
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [3:0] RST_ATTR = 4'h0;
  localparam logic [5:0] RST_CTL = 6'h00;
  localparam logic [1:0] RST_MAP = 2'h0;
  localparam int STRUCT_ALT_BIT = 9;
  localparam int STRUCT_CH_LSB = 4;
  // attribute bit positions
  localparam int ATTR_BURST = 0;
  localparam int ATTR_ALT = 1;
  localparam int ATTR_HIPRI = 2;
  localparam int ATTR_REQMASK = 3;
  // control word fields
  localparam int CTL_SIZE_LSB = 0;
  localparam int CTL_SRC_INC_LSB = 2;
  localparam int CTL_DST_INC_LSB = 4;
  localparam logic [1:0] INC_NONE = 2'h3;
  // transfer word fields
  localparam int XFER_CNT_LSB = 0;
  localparam int XFER_MODE_LSB = 16;
  // host register map, byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ARG = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_CHAN_LSB = 8;
  localparam int CMD_ALT_BIT = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    OP_NOP, OP_GLOBAL_EN, OP_GLOBAL_DIS, OP_BASE_SET, OP_STRUCT_ADDR,
    OP_ATTR_SET, OP_ATTR_CLR, OP_ATTR_GET, OP_CTRL_SET, OP_SRC_SET,
    OP_DST_SET, OP_XFER_SET, OP_CH_EN, OP_CH_DIS, OP_CH_ISEN,
    OP_MODE_GET, OP_SIZE_GET, OP_SW_REQ, OP_MAP_SET, OP_DONE_GET,
    OP_ERR_GET, OP_ERR_CLR
  } dmac_op_t;

  typedef enum logic [2:0] {
    MODE_STOP, MODE_BASIC, MODE_AUTO, MODE_PINGPONG, MODE_MEM_SG, MODE_PER_SG
  } dmac_mode_t;
endpackage : dmac_pkg
